/* src/bbnss_defs.vh */
// constants for the bus numbering and downstream status register bank
`ifndef BBNSS_DEFS_VH
`define BBNSS_DEFS_VH

// ****************************************
// register byte addresses
// ****************************************
`define BBNSS_BUSNUM_OFS     12'h018
`define BBNSS_DSTAT_OFS      12'h01C
`define BBNSS_IRQ_MASK_OFS   12'h040
`define BBNSS_HOLD_CNT_OFS   12'h044

// ****************************************
// field positions
// ****************************************
`define BBNSS_HOLD_MSB       31
`define BBNSS_HOLD_LSB       27
`define BBNSS_SUB_MSB        23
`define BBNSS_SUB_LSB        16
`define BBNSS_SEC_MSB        15
`define BBNSS_SEC_LSB        8
`define BBNSS_PRI_MSB        7
`define BBNSS_PRI_LSB        0
`define BBNSS_PE_BIT         31
`define BBNSS_SERR_BIT       30
`define BBNSS_MA_BIT         29
`define BBNSS_TA_BIT         28

// ****************************************
// reset values
// ****************************************
`define BBNSS_HOLD_RST_PCI   5'h00
`define BBNSS_HOLD_RST_PCIX  5'h08
`define BBNSS_BUSNUM_RST     8'h00
`define BBNSS_HOLD_LOW_ZERO  3'h0
// hardwired part of the downstream status word outside this bank
`define BBNSS_DSTAT_FIXED    32'h02A0_0101

// ****************************************
// axi responses
// ****************************************
`define BBNSS_RESP_OKAY      2'h0
`define BBNSS_RESP_SLVERR    2'h2

`endif

/* src/bbnss_top.v */
// bus numbering, hold timer and downstream status flags behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "bbnss_defs.vh"
// How it works
// - hold timer is five writable top bits; three bits below read zero.
// - bus ownership kept at least hold value times eight clocks during bursts.
// - hold field resets to 00000 in PCI mode, 01000 in PCI-X mode.
// - subordinate bus number, writable, reset zero, bounds type 1 claim.
// - secondary bus number, writable, reset zero, selects type 1 to type 0.
// - primary bus number, writable, reset zero, lowest byte.
// - parity flag set by address, target write or master read parity errors.
// - system error flag set while system error line is seen asserted.
// - master abort flag set when own secondary transaction is master aborted.
// - target abort flag set when own secondary transaction is target aborted.
module bbnss_top (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // secondary bus mode, high for PCI-X
    input  wire        pcix_mode,
    // secondary bus events, one-cycle pulses or levels
    input  wire        addr_parity_err_target,
    input  wire        data_parity_err_target_write,
    input  wire        data_parity_err_master_read,
    input  wire        system_error_line_n,
    input  wire        master_abort_seen,
    input  wire        target_abort_seen,
    // burst ownership
    input  wire        burst_owner,
    output reg         hold_may_release,
    // type 1 configuration request decode
    input  wire        cfg_type1_valid,
    input  wire [7:0]  cfg_bus_num,
    output reg         cfg_to_type0,
    output reg         cfg_forward_type1,
    output reg         cfg_ignore,
    // interrupt
    output reg         irq
);

    // ****************************************
    // state
    // ****************************************
    reg  [4:0]  downstream_hold_timer_reg;
    reg  [7:0]  sub_bus_reg;
    reg  [7:0]  sec_bus_reg;
    reg  [7:0]  pri_bus_reg;
    reg  [3:0]  flags_reg;   // pe, serr, ma, ta in bits 3..0
    reg  [3:0]  irq_mask_reg;
    reg  [7:0]  hold_cnt_reg;
    reg  [11:0] awaddr_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    reg         aw_have_reg;
    reg         w_have_reg;

    wire [7:0]  hold_cycles;
    wire [3:0]  events;
    wire        do_write;
    wire        do_read;
    wire [31:0] busnum_word;
    wire [31:0] dstat_word;
    reg  [31:0] rd_word;
    reg         rd_hit;
    reg  [3:0]  w1c_clear;
    reg  [3:0]  rd_clear;
    reg  [3:0]  flags_next;

    // in steps of eight clocks since the low three bits are always zero
    assign hold_cycles = {downstream_hold_timer_reg, `BBNSS_HOLD_LOW_ZERO};
    assign events = {addr_parity_err_target | data_parity_err_target_write
                     | data_parity_err_master_read,
                     ~system_error_line_n,
                     master_abort_seen,
                     target_abort_seen};

    assign busnum_word = {downstream_hold_timer_reg, `BBNSS_HOLD_LOW_ZERO,
                          sub_bus_reg, sec_bus_reg, pri_bus_reg};
    // flags over the fixed low bits; the hardwired top nibble is replaced by the flags
    assign dstat_word  = {flags_reg, 28'h0000000} | (`BBNSS_DSTAT_FIXED & 32'h0FFF_FFFF);
    // bus slave
    assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    assign do_read  = s_axi_arvalid & s_axi_arready;

    // ****************************************
    // read mux and flag clear terms
    // ****************************************
    always @* begin
        rd_word  = 32'h0000_0000;
        rd_hit   = 1'b1;
        rd_clear = 4'h0;
        case (s_axi_araddr)
            `BBNSS_BUSNUM_OFS:   rd_word = busnum_word;
            `BBNSS_DSTAT_OFS:    rd_word = dstat_word;
            `BBNSS_IRQ_MASK_OFS: rd_word = {28'h0000000, irq_mask_reg};
            `BBNSS_HOLD_CNT_OFS: rd_word = {24'h000000, hold_cnt_reg};
            default:             rd_hit  = 1'b0;
        endcase
        // reading the status word also clears what it showed
        if (do_read && s_axi_araddr == `BBNSS_DSTAT_OFS) begin
            rd_clear = flags_reg;
        end
        w1c_clear = 4'h0;
        if (do_write && awaddr_reg == `BBNSS_DSTAT_OFS && wstrb_reg[3]) begin
            w1c_clear = wdata_reg[31:28];
        end
        // a new event beats a clear in the same cycle
        flags_next = (flags_reg & ~(w1c_clear | rd_clear)) | events;
    end

    // ****************************************
    // registers and bus handshakes
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            downstream_hold_timer_reg <= pcix_mode ? `BBNSS_HOLD_RST_PCIX : `BBNSS_HOLD_RST_PCI;
            sub_bus_reg   <= `BBNSS_BUSNUM_RST;
            sec_bus_reg   <= `BBNSS_BUSNUM_RST;
            pri_bus_reg   <= `BBNSS_BUSNUM_RST;
            flags_reg     <= 4'h0;
            irq_mask_reg  <= 4'h0;
            awaddr_reg    <= 12'h000;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BBNSS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `BBNSS_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            irq           <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            irq       <= |(flags_next & irq_mask_reg);
            // write address and data taken independently
            s_axi_awready <= ~aw_have_reg & ~(s_axi_awvalid & s_axi_awready);
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg  <= s_axi_awaddr;
                aw_have_reg <= 1'b1;
            end
            s_axi_wready <= ~w_have_reg & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
                w_have_reg <= 1'b1;
            end
            if (do_write) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `BBNSS_RESP_OKAY;
                case (awaddr_reg)
                    `BBNSS_BUSNUM_OFS: begin
                        if (wstrb_reg[3]) downstream_hold_timer_reg <= wdata_reg[`BBNSS_HOLD_MSB:`BBNSS_HOLD_LSB];
                        if (wstrb_reg[2]) sub_bus_reg <= wdata_reg[`BBNSS_SUB_MSB:`BBNSS_SUB_LSB];
                        if (wstrb_reg[1]) sec_bus_reg <= wdata_reg[`BBNSS_SEC_MSB:`BBNSS_SEC_LSB];
                        if (wstrb_reg[0]) pri_bus_reg <= wdata_reg[`BBNSS_PRI_MSB:`BBNSS_PRI_LSB];
                    end
                    `BBNSS_DSTAT_OFS: begin
                    end
                    `BBNSS_IRQ_MASK_OFS: begin
                        if (wstrb_reg[0]) irq_mask_reg <= wdata_reg[3:0];
                    end
                    `BBNSS_HOLD_CNT_OFS: begin
                    end
                    default: s_axi_bresp <= `BBNSS_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // read: one outstanding, address taken only while no data pending
            s_axi_arready <= ~s_axi_rvalid & ~do_read & ~s_axi_arready;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `BBNSS_RESP_OKAY : `BBNSS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // burst hold counter
    // ****************************************
    // counts clocks of ownership; release is allowed once the programmed minimum has passed
    always @(posedge aclk) begin
        if (!aresetn) begin
            hold_cnt_reg     <= 8'h00;
            hold_may_release <= 1'b0;
        end else if (!burst_owner) begin
            hold_cnt_reg     <= 8'h00;
            hold_may_release <= 1'b0;
        end else begin
            if (hold_cnt_reg != 8'hFF) begin
                hold_cnt_reg <= hold_cnt_reg + 8'h01;
            end
            // nine bits so the saturated count does not wrap and drop the release
            hold_may_release <= ({1'b0, hold_cnt_reg} + 9'h001) >= {1'b0, hold_cycles};
        end
    end

    // ****************************************
    // type 1 configuration decode
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg_to_type0      <= 1'b0;
            cfg_forward_type1 <= 1'b0;
            cfg_ignore        <= 1'b0;
        end else begin
            cfg_to_type0      <= cfg_type1_valid && cfg_bus_num == sec_bus_reg;
            cfg_forward_type1 <= cfg_type1_valid && cfg_bus_num > sec_bus_reg
                                 && cfg_bus_num <= sub_bus_reg;
            cfg_ignore        <= cfg_type1_valid && (cfg_bus_num < sec_bus_reg
                                 || cfg_bus_num > sub_bus_reg);
        end
    end

endmodule

/* dv/bbnss_properties.sv */
// checker of the bus numbering and downstream status bank
`timescale 1ns/1ps
module bbnss_props (
    // watched ports
    input wire        aclk, aresetn, pcix_mode, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire [11:0] s_axi_awaddr,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        addr_parity_err_target, data_parity_err_target_write, data_parity_err_master_read,
    input wire        system_error_line_n, master_abort_seen, target_abort_seen, burst_owner, hold_may_release,
    input wire        cfg_type1_valid, cfg_to_type0, cfg_forward_type1, cfg_ignore, irq,
    input wire [7:0]  cfg_bus_num
);
    // ********
    // shadow of the writable fields other than the primary bus number
    // ********
    reg  [7:0]  sec_reg, sub_reg;
    reg  [4:0]  hold_reg;
    reg  [3:0]  mask_reg;
    reg  [10:0] own_reg;
    wire        wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire        bus_wr = wr_go && s_axi_awaddr == 12'h018;
    wire [10:0] lim = {3'h0, hold_reg, 3'h0};
    always @(posedge aclk) begin
        own_reg <= burst_owner ? own_reg + 11'h001 : 11'h000;
        if (!aresetn) begin
            {sub_reg, sec_reg, mask_reg} <= 20'h00000;
            hold_reg <= pcix_mode ? 5'h08 : 5'h00;
        end else begin
            if (bus_wr && s_axi_wstrb[3]) hold_reg <= s_axi_wdata[31:27];
            if (bus_wr && s_axi_wstrb[2]) sub_reg <= s_axi_wdata[23:16];
            if (bus_wr && s_axi_wstrb[1]) sec_reg <= s_axi_wdata[15:8];
            if (wr_go && s_axi_awaddr == 12'h040 && s_axi_wstrb[0]) mask_reg <= s_axi_wdata[3:0];
        end
    end
    // ********
    // properties; a margin of two cycles allows for the count's pipeline
    // ********
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_HOLD_EARLY: assert property (burst_owner && own_reg + 11'h002 < lim |-> !hold_may_release)
        else $error("bus released before hold time");
    AST_HOLD_LATE: assert property (burst_owner && own_reg > lim + 11'h002 |-> hold_may_release)
        else $error("bus not released after hold time");
    AST_TYPE0: assert property (cfg_type1_valid && cfg_bus_num == sec_reg |=> cfg_to_type0 && !cfg_ignore)
        else $error("request to own secondary bus not converted");
    AST_FORWARD: assert property (cfg_type1_valid && cfg_bus_num > sec_reg && cfg_bus_num <= sub_reg
        |=> cfg_forward_type1 && !cfg_to_type0 && !cfg_ignore) else $error("downstream request not forwarded");
    AST_IGNORE: assert property (cfg_type1_valid && cfg_bus_num != sec_reg
        && (cfg_bus_num < sec_reg || cfg_bus_num > sub_reg) |=> cfg_ignore && !cfg_forward_type1)
        else $error("request outside the range not ignored");
    AST_PE_IRQ: assert property ((addr_parity_err_target || data_parity_err_target_write
        || data_parity_err_master_read) && mask_reg[3] |=> irq) else $error("parity event lost");
    AST_SERR_IRQ: assert property (!system_error_line_n && mask_reg[2] |=> irq)
        else $error("system error event lost");
    AST_ABORT_IRQ: assert property (master_abort_seen && mask_reg[1] || target_abort_seen && mask_reg[0]
        |=> irq) else $error("abort event lost");
endmodule
bind bbnss_top bbnss_props i_props (.*);

/* dv/bbnss_sec_bus_model.sv */
// model of the secondary bus that raises error events toward the bridge
`timescale 1ns/1ps
module bbnss_sec_bus_model (
    // command from the bench
    input  wire       aclk, ev_go,
    input  wire [2:0] ev_code,
    // event lines toward the bridge
    output wire       addr_parity_err_target, data_parity_err_target_write, data_parity_err_master_read,
    output wire       system_error_line_n, master_abort_seen, target_abort_seen
);
    reg [5:0] hot_reg = 6'h00;
    // each event lasts one cycle
    always @(posedge aclk) hot_reg <= ev_go ? 6'h01 << ev_code : 6'h00;
    assign addr_parity_err_target       = hot_reg[0];
    assign data_parity_err_target_write = hot_reg[1];
    assign data_parity_err_master_read  = hot_reg[2];
    // line is pulled up when no one drives it low
    assign system_error_line_n          = ~hot_reg[3];
    assign master_abort_seen            = hot_reg[4];
    assign target_abort_seen            = hot_reg[5];
endmodule

/* dv/bbnss_top_test.sv */
// self-checking bench for the bus numbering and downstream status bank
`timescale 1ns/1ps
`include "bbnss_defs.vh"
`define CHK(nm, e, g) begin num_checks = num_checks + 1; if ((g) !== (e)) begin errors = errors + 1; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module bbnss_top_test;
    reg         aclk = 1'b0, aresetn = 1'b0, pcix_mode = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, burst_owner = 1'b0;
    reg         cfg_type1_valid = 1'b0, ev_go = 1'b0;
    reg  [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    reg  [31:0] s_axi_wdata = 32'h0000_0000, word, flag;
    reg  [3:0]  s_axi_wstrb = 4'h0;
    reg  [7:0]  cfg_bus_num = 8'h00, sec, sub, b;
    reg  [2:0]  ev_code = 3'h0;
    reg  [15:0] seed = 16'h0057;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, hold_may_release, irq;
    wire        cfg_to_type0, cfg_forward_type1, cfg_ignore, addr_parity_err_target, system_error_line_n;
    wire        data_parity_err_target_write, data_parity_err_master_read, master_abort_seen, target_abort_seen;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     errors = 0, num_checks = 0, i, m, n;
    always #2 aclk = ~aclk;
    bbnss_top i_dut (.*);
    bbnss_sec_bus_model i_far (.*);
    // ********
    // helpers
    // ********
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // one-hot {type0, forward, ignore}
    function [2:0] dec(input [7:0] bn, input [7:0] s, input [7:0] u);
        dec = (bn == s) ? 3'h4 : (bn > s && bn <= u) ? 3'h2 : 3'h1;
    endfunction
    function [31:0] merge(input [31:0] o, input [31:0] d, input [3:0] st);
        reg [31:0] sm;
        begin
            sm = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
            merge = ((o & ~sm) | (d & sm)) & 32'hF8FF_FFFF;
        end
    endfunction
    task end_sim;
        begin
            $display("checks %0d errors %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task hang;
        begin
            $display("MISMATCH handshake expected done seen timeout");
            errors = errors + 1;
            end_sim;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d, input [3:0] st, input [1:0] er);
        begin
            @(posedge aclk);
            {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, st};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            n = 0;
            do begin
                @(posedge aclk);
                n = n + 1;
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (!s_axi_bvalid && n < 64);
            s_axi_bready <= 1'b0;
            if (n >= 64) hang;
            `CHK("bresp", er, s_axi_bresp)
        end
    endtask
    task rd(input [11:0] a, input [31:0] e, input [1:0] er);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            n = 0;
            do begin
                @(posedge aclk);
                n = n + 1;
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (!s_axi_rvalid && n < 64);
            s_axi_rready <= 1'b0;
            if (n >= 64) hang;
            `CHK("rdata", e, s_axi_rdata)
            `CHK("rresp", er, s_axi_rresp)
        end
    endtask
    // event reaches the flags two edges after the command
    task fire(input [2:0] c);
        begin
            @(posedge aclk);
            {ev_code, ev_go} <= {c, 1'b1};
            @(posedge aclk);
            ev_go <= 1'b0;
            repeat (2) @(posedge aclk);
            #1;
        end
    endtask
    // ********
    // scenarios
    // ********
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`BBNSS_BUSNUM_OFS, 32'h0000_0000, `BBNSS_RESP_OKAY);
        rd(`BBNSS_DSTAT_OFS, `BBNSS_DSTAT_FIXED, `BBNSS_RESP_OKAY);
        word = 32'h0000_0000;
        for (i = 0; i < 12; i = i + 1) begin
            seed = lfsr(seed);
            flag = (i == 0) ? 32'hFFFF_FFFF : {seed, lfsr(seed)};
            wr(`BBNSS_BUSNUM_OFS, flag, (i == 0) ? 4'hF : seed[3:0], `BBNSS_RESP_OKAY);
            word = merge(word, flag, (i == 0) ? 4'hF : seed[3:0]);
            rd(`BBNSS_BUSNUM_OFS, word, `BBNSS_RESP_OKAY);
        end
        wr(12'h100, 32'hFFFF_FFFF, 4'hF, `BBNSS_RESP_SLVERR);
        rd(12'h100, 32'h0000_0000, `BBNSS_RESP_SLVERR);
        for (i = 0; i < 40; i = i + 1) begin
            seed = lfsr(seed);
            if (i % 5 == 0) begin
                sec = seed[7:0] & 8'h7F;
                sub = sec + {1'b0, seed[14:8]};
                wr(`BBNSS_BUSNUM_OFS, {8'h00, sub, sec, 8'h00}, 4'h6, `BBNSS_RESP_OKAY);
            end
            b = (i % 5 == 0) ? sec : (i % 5 == 1) ? sub : (i % 5 == 2) ? sec - 8'h01 : (i % 5 == 3) ? sub + 8'h01 : seed[15:8];
            @(posedge aclk);
            {cfg_type1_valid, cfg_bus_num} <= {1'b1, b};
            @(posedge aclk);
            cfg_type1_valid <= 1'b0;
            #1 `CHK("decode", dec(b, sec, sub), {cfg_to_type0, cfg_forward_type1, cfg_ignore})
        end
        for (i = 0; i < 6; i = i + 1) begin
            m = (i < 3) ? 3 : 5 - i;
            flag = 32'h1 << (28 + m);
            wr(`BBNSS_IRQ_MASK_OFS, 32'h1 << m, 4'h1, `BBNSS_RESP_OKAY);
            fire(i[2:0]);
            `CHK("irq set", 1'b1, irq)
            rd(`BBNSS_DSTAT_OFS, `BBNSS_DSTAT_FIXED | flag, `BBNSS_RESP_OKAY);
            rd(`BBNSS_DSTAT_OFS, `BBNSS_DSTAT_FIXED, `BBNSS_RESP_OKAY);
            `CHK("irq low", 1'b0, irq)
            fire(i[2:0]);
            wr(`BBNSS_DSTAT_OFS, flag, 4'h8, `BBNSS_RESP_OKAY);
            rd(`BBNSS_DSTAT_OFS, `BBNSS_DSTAT_FIXED, `BBNSS_RESP_OKAY);
            wr(`BBNSS_IRQ_MASK_OFS, 32'h0, 4'h1, `BBNSS_RESP_OKAY);
            fire(i[2:0]);
            `CHK("irq masked", 1'b0, irq)
            rd(`BBNSS_DSTAT_OFS, `BBNSS_DSTAT_FIXED | flag, `BBNSS_RESP_OKAY);
        end
        for (i = 1; i < 4; i = i + 1) begin
            wr(`BBNSS_BUSNUM_OFS, i << 27, 4'h8, `BBNSS_RESP_OKAY);
            burst_owner <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                n = n + 1;
            end while (!hold_may_release && n < 64);
            burst_owner <= 1'b0;
            `CHK("release", 1'b1, (n >= i * 8 - 2 && n <= i * 8 + 3))
        end
        rd(`BBNSS_HOLD_CNT_OFS, 32'h0000_0000, `BBNSS_RESP_OKAY);
        rd(`BBNSS_IRQ_MASK_OFS, 32'h0000_0000, `BBNSS_RESP_OKAY);
        @(posedge aclk);
        {aresetn, pcix_mode} <= 2'h1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`BBNSS_BUSNUM_OFS, 32'h4000_0000, `BBNSS_RESP_OKAY);
        end_sim;
    end
endmodule
